// >>> pkg/fcs_cfg.svh
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

// Register offsets
`define FCS_OFF_STAT 8'h00
`define FCS_OFF_CNFG 8'h01
`define FCS_OFF_PROT 8'h02
`define FCS_OFF_SLOT0 8'h04
`define FCS_OFF_SLOTB 8'h0f
`define FCS_SLOT_NUM 12

// Status bit positions
`define FCS_ST_DONE 7
`define FCS_ST_RDCOL 6
`define FCS_ST_ACC 5
`define FCS_ST_FPV 4
`define FCS_ST_MGS 0
// Config bit position
`define FCS_CN_SUSP 4

// Reset values
`define FCS_PROT_RST 8'h00
`define FCS_ERASED 8'hff

// Command codes
`define FCS_CMD_PCHECK 8'h02
`define FCS_CMD_RDRES 8'h03
`define FCS_CMD_PROG 8'h06
`define FCS_CMD_ERSSEC 8'h09

// Resource selects and ranges
`define FCS_SEL_INFO 8'h00
`define FCS_SEL_VER 8'h01
`define FCS_INFO_TOP 24'h0000ff
`define FCS_VER_TOP 24'h000007

// Margin choices
`define FCS_MG_USER 8'h01
`define FCS_MG_FACT 8'h02

// Array geometry
`define FCS_FLASH_TOP 24'h007fff
`define FCS_SECT_LAST 10'h3ff
`define FCS_REG_LSB 12

// Timing
`define FCS_CLK_NS 25
`define FCS_PROG_NS 7500
`define FCS_PROG_CYC ((`FCS_PROG_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_PULSE_NS 100000
`define FCS_PULSE_CYC ((`FCS_PULSE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_PULSES 4'h8

`endif

// >>> pkg/fcs_pkg.sv
package fcs_pkg;

typedef enum logic [3:0] {
    FCS_IDLE = 4'b0000,
    FCS_CHECK = 4'b0001,
    FCS_PROG_WR = 4'b0010,
    FCS_PROG_WAIT = 4'b0011,
    FCS_RD_ISSUE = 4'b0100,
    FCS_RD_CAP = 4'b0101,
    FCS_ERS_PULSE = 4'b0110,
    FCS_ERS_WAIT = 4'b0111,
    FCS_DONE = 4'b1000
} fcs_state_e;

typedef struct packed {
    logic [23:0] addr;
    logic [7:0] wdata;
    logic read;
    logic prog;
    logic erase;
    logic [1:0] marginLvl;
    logic marginZero;
} fcs_arr_s;

endpackage

// >>> rtl/fcs_arg_check.sv
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module fcs_arg_check import fcs_pkg::*; (
    // Command arguments
    input wire logic [7:0] cmd,
    input wire logic [23:0] addr,
    input wire logic [7:0] sel,
    input wire logic [7:0] margin,
    input wire logic [7:0] prot,
    input wire logic cmdUnavail,
    // Verdict
    output logic known,
    output logic access_error_flag,
    output logic protErr
);
    logic aligned;
    logic inFlash;

    always_comb begin
        aligned = (addr[1:0] == 2'b00);
        inFlash = (addr <= `FCS_FLASH_TOP);
        known = 1'b1;
        access_error_flag = cmdUnavail;
        protErr = 1'b0;
        case (cmd)
            `FCS_CMD_RDRES: begin
                if (!aligned || !((sel == `FCS_SEL_INFO && addr <= `FCS_INFO_TOP) ||
                    (sel == `FCS_SEL_VER && addr <= `FCS_VER_TOP))) begin
                    access_error_flag = 1'b1;
                end
            end
            `FCS_CMD_PCHECK: begin
                if (!aligned || !inFlash || !(margin == `FCS_MG_USER || margin == `FCS_MG_FACT)) begin
                    access_error_flag = 1'b1;
                end
            end
            `FCS_CMD_PROG, `FCS_CMD_ERSSEC: begin
                if (!aligned || !inFlash) begin
                    access_error_flag = 1'b1;
                end
                protErr = !access_error_flag && prot[addr[`FCS_REG_LSB+2:`FCS_REG_LSB]];
            end
            default: begin
                known = 1'b0;
                access_error_flag = 1'b1;
            end
        endcase
    end
endmodule // fcs_arg_check

// >>> rtl/fcs_resource_rom.sv
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module fcs_resource_rom import fcs_pkg::*; #(
    // Arbitrary value, not tied to any real part
    parameter logic [63:0] VERSION_ID = 64'h0123_4567_89ab_cdef
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Info row load
    input wire logic infoWrEn,
    input wire logic [7:0] infoAddr,
    input wire logic [7:0] infoData,
    // Lookup
    input wire logic [7:0] sel,
    input wire logic [7:0] addr,
    output logic [31:0] word
);
    logic [7:0] infoReg [0:255];
    logic [7:0] infoNext [0:255];

    function automatic logic [7:0] verByte(input logic [2:0] i);
        verByte = VERSION_ID[{i, 3'b000} +: 8];
    endfunction

    always_comb begin
        infoNext = infoReg;
        if (infoWrEn) begin
            infoNext[infoAddr] = infoData;
        end
        // Lowest address lands in the top byte
        if (sel == `FCS_SEL_VER) begin
            word = {verByte(addr[2:0]), verByte(addr[2:0] + 3'd1),
                    verByte(addr[2:0] + 3'd2), verByte(addr[2:0] + 3'd3)};
        end else begin
            word = {infoReg[addr], infoReg[8'(addr + 8'd1)],
                    infoReg[8'(addr + 8'd2)], infoReg[8'(addr + 8'd3)]};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < 256; i++) begin
                infoReg[i] <= `FCS_ERASED;
            end
        end else if (ce) begin
            infoReg <= infoNext;
        end
    end
endmodule // fcs_resource_rom

// >>> rtl/fcs_sequencer.sv
// How it works
// - Program check flags bad address or margin as error, mismatch as verify fail.
// - Select 0x00 is the 256-byte info row, 0x01 the 8-byte version id.
// - Resource read returns four bytes, high byte in slot 4, then completes.
// - Bad select, out-of-range or misaligned address gives error, no read.
// - Byte 3 goes to start, byte 0 to start plus three.
// - Programming clears bits only; an erased bit left high flags verify fail.
// - Protected target gives protection flag; bad address gives error flag.
// - Code 0x09 erases the whole sector, verifies it, then completes.
// - Protected sector aborts with protection flag; bad address gives error flag.
// - Suspend bit is sampled between erase pulses; suspension halts and completes.
// - While suspend is set only status and config writes are taken.
// - Erase finishing first clears suspend bit; a real suspension keeps it.
// - While complete is set, software may only clear the suspend bit.
// - Launch with suspend still set resumes the erase and clears the bit.
// - Unknown command code gives error flag and no execution.
// - No launch while error or protection flag is set.
// - Array read during a running command sets the collision flag.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module fcs_sequencer import fcs_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // Flash array
    output fcs_arr_s arrReq,
    input wire logic [7:0] arrRdata,
    // System side
    input wire logic cpuFlashRead,
    input wire logic cmdUnavail,
    input wire logic infoWrEn,
    input wire logic [7:0] infoAddr,
    input wire logic [7:0] infoData,
    output logic busy
);
    fcs_state_e stateReg, stateNext;
    logic doneReg, doneNext;
    logic rdcolReg, rdcolNext;
    logic accReg, accNext;
    logic fpvReg, fpvNext;
    logic mgsReg, mgsNext;
    logic suspReg, suspNext;
    logic pausedReg, pausedNext;
    logic passReg, passNext;
    logic [7:0] protReg, protNext;
    logic [7:0] slotReg [0:`FCS_SLOT_NUM-1];
    logic [7:0] slotNext [0:`FCS_SLOT_NUM-1];
    logic [9:0] idxReg, idxNext;
    logic [11:0] cntReg, cntNext;
    logic [3:0] pulseReg, pulseNext;
    logic [7:0] rdataReg, rdataNext;
    fcs_arr_s arrReg, arrNext;
    logic [23:0] startAddr;
    logic known, argAcc, argProt;
    logic [31:0] resWord;
    logic launch;

    function automatic logic [3:0] slotOf(input logic [7:0] a);
        slotOf = 4'(a - `FCS_OFF_SLOT0);
    endfunction

    assign startAddr = {slotReg[1], slotReg[2], slotReg[3]};
    assign regRdata = rdataReg;
    assign arrReq = arrReg;
    assign busy = !doneReg;

    fcs_arg_check uCheck (
        .cmd(slotReg[0]),
        .addr(startAddr),
        .sel(slotReg[8]),
        .margin(slotReg[4]),
        .prot(protReg),
        .cmdUnavail(cmdUnavail),
        .known(known),
        .access_error_flag(argAcc),
        .protErr(argProt)
    );

    fcs_resource_rom uRes (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .infoWrEn(infoWrEn),
        .infoAddr(infoAddr),
        .infoData(infoData),
        .sel(slotReg[8]),
        .addr(startAddr[7:0]),
        .word(resWord)
    );

    always_comb begin
        stateNext = stateReg;
        doneNext = doneReg;
        rdcolNext = rdcolReg;
        accNext = accReg;
        fpvNext = fpvReg;
        mgsNext = mgsReg;
        suspNext = suspReg;
        pausedNext = pausedReg;
        passNext = passReg;
        protNext = protReg;
        slotNext = slotReg;
        idxNext = idxReg;
        cntNext = cntReg;
        pulseNext = pulseReg;
        rdataNext = rdataReg;
        arrNext = arrReg;
        arrNext.read = 1'b0;
        arrNext.prog = 1'b0;
        arrNext.erase = 1'b0;
        launch = 1'b0;

        // Software side: reads answer one cycle later
        if (regRd) begin
            case (regAddr)
                `FCS_OFF_STAT: rdataNext = {doneReg, rdcolReg, accReg, fpvReg, 3'b000, mgsReg};
                `FCS_OFF_CNFG: rdataNext = {3'b000, suspReg, 4'b0000};
                `FCS_OFF_PROT: rdataNext = protReg;
                default: begin
                    if (regAddr >= `FCS_OFF_SLOT0 && regAddr <= `FCS_OFF_SLOTB) begin
                        rdataNext = slotReg[slotOf(regAddr)];
                    end else begin
                        rdataNext = 8'h00;
                    end
                end
            endcase
        end
        if (regWr) begin
            if (regAddr == `FCS_OFF_STAT) begin
                if (regWdata[`FCS_ST_RDCOL]) rdcolNext = 1'b0;
                if (regWdata[`FCS_ST_ACC]) accNext = 1'b0;
                if (regWdata[`FCS_ST_FPV]) fpvNext = 1'b0;
                // Flags are sampled before the clears above take effect
                if (regWdata[`FCS_ST_DONE] && doneReg && !accReg && !fpvReg) begin
                    launch = 1'b1;
                end
            end else if (regAddr == `FCS_OFF_CNFG) begin
                if (doneReg) begin
                    suspNext = suspReg && regWdata[`FCS_CN_SUSP];
                end else if (slotReg[0] == `FCS_CMD_ERSSEC) begin
                    suspNext = regWdata[`FCS_CN_SUSP];
                end
            end else if (!suspReg && doneReg) begin
                if (regAddr == `FCS_OFF_PROT) begin
                    protNext = regWdata;
                end else if (regAddr >= `FCS_OFF_SLOT0 && regAddr <= `FCS_OFF_SLOTB) begin
                    slotNext[slotOf(regAddr)] = regWdata;
                end
            end
        end

        if (launch) begin
            doneNext = 1'b0;
            if (pausedReg && suspReg) begin
                suspNext = 1'b0;
                stateNext = FCS_ERS_PULSE;
            end else begin
                // Dropping the suspend bit before launch abandons the erase
                pausedNext = 1'b0;
                mgsNext = 1'b0;
                stateNext = FCS_CHECK;
            end
        end

        case (stateReg)
            FCS_IDLE: begin
            end
            FCS_CHECK: begin
                idxNext = 10'h000;
                passNext = 1'b0;
                pulseNext = 4'h0;
                if (argAcc) begin
                    accNext = 1'b1;
                    stateNext = FCS_DONE;
                end else if (argProt) begin
                    fpvNext = 1'b1;
                    stateNext = FCS_DONE;
                end else begin
                    case (slotReg[0])
                        `FCS_CMD_RDRES: begin
                            slotNext[4] = resWord[31:24];
                            slotNext[5] = resWord[23:16];
                            slotNext[6] = resWord[15:8];
                            slotNext[7] = resWord[7:0];
                            stateNext = FCS_DONE;
                        end
                        `FCS_CMD_PROG: stateNext = FCS_PROG_WR;
                        `FCS_CMD_PCHECK: stateNext = FCS_RD_ISSUE;
                        `FCS_CMD_ERSSEC: stateNext = FCS_ERS_PULSE;
                        default: stateNext = FCS_DONE;
                    endcase
                end
            end
            FCS_PROG_WR: begin
                arrNext.addr = 24'(startAddr + {14'h0000, idxReg});
                arrNext.wdata = slotReg[4'(7 - idxReg[1:0])];
                arrNext.prog = 1'b1;
                arrNext.marginLvl = 2'b00;
                arrNext.marginZero = 1'b0;
                cntNext = 12'(`FCS_PROG_CYC - 1);
                stateNext = FCS_PROG_WAIT;
            end
            FCS_PROG_WAIT: begin
                cntNext = cntReg - 12'h001;
                if (cntReg == 12'h000) begin
                    arrNext.read = 1'b1;
                    stateNext = FCS_RD_CAP;
                end
            end
            FCS_RD_ISSUE: begin
                if (slotReg[0] == `FCS_CMD_ERSSEC) begin
                    arrNext.addr = {startAddr[23:10], idxReg};
                    arrNext.marginLvl = 2'b00;
                end else begin
                    arrNext.addr = 24'(startAddr + {14'h0000, idxReg});
                    arrNext.marginLvl = slotReg[4][1:0];
                end
                arrNext.marginZero = passReg;
                arrNext.read = 1'b1;
                stateNext = FCS_RD_CAP;
            end
            FCS_RD_CAP: begin
                // Array answers in the same cycle as the read strobe
                stateNext = FCS_RD_ISSUE;
                idxNext = idxReg + 10'h001;
                case (slotReg[0])
                    `FCS_CMD_PROG: begin
                        if ((arrRdata & ~arrReg.wdata) != 8'h00) mgsNext = 1'b1;
                        stateNext = (idxReg == 10'h003) ? FCS_DONE : FCS_PROG_WR;
                    end
                    `FCS_CMD_PCHECK: begin
                        if (arrRdata != slotReg[4'(11 - idxReg[1:0])]) mgsNext = 1'b1;
                        if (idxReg == 10'h003) begin
                            idxNext = 10'h000;
                            passNext = 1'b1;
                            if (passReg) stateNext = FCS_DONE;
                        end
                    end
                    default: begin
                        if (arrRdata != `FCS_ERASED) mgsNext = 1'b1;
                        if (idxReg == `FCS_SECT_LAST) begin
                            suspNext = 1'b0;
                            stateNext = FCS_DONE;
                        end
                    end
                endcase
            end
            FCS_ERS_PULSE: begin
                arrNext.addr = startAddr;
                arrNext.erase = 1'b1;
                cntNext = 12'(`FCS_PULSE_CYC - 1);
                stateNext = FCS_ERS_WAIT;
            end
            FCS_ERS_WAIT: begin
                cntNext = cntReg - 12'h001;
                if (cntReg == 12'h000) begin
                    pulseNext = pulseReg + 4'h1;
                    if (pulseReg == `FCS_PULSES - 4'h1) begin
                        idxNext = 10'h000;
                        stateNext = FCS_RD_ISSUE;
                    end else if (suspReg) begin
                        // Pulse boundary is the only safe place to stop
                        pausedNext = 1'b1;
                        doneNext = 1'b1;
                        stateNext = FCS_IDLE;
                    end else begin
                        stateNext = FCS_ERS_PULSE;
                    end
                end
            end
            FCS_DONE: begin
                doneNext = 1'b1;
                stateNext = FCS_IDLE;
            end
            default: stateNext = FCS_IDLE;
        endcase

        // Hardware set wins over a software clear in the same cycle
        if (cpuFlashRead && !doneReg) begin
            rdcolNext = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stateReg <= FCS_IDLE;
            doneReg <= 1'b1;
            rdcolReg <= 1'b0;
            accReg <= 1'b0;
            fpvReg <= 1'b0;
            mgsReg <= 1'b0;
            suspReg <= 1'b0;
            pausedReg <= 1'b0;
            passReg <= 1'b0;
            protReg <= `FCS_PROT_RST;
            for (int i = 0; i < `FCS_SLOT_NUM; i++) begin
                slotReg[i] <= 8'h00;
            end
            idxReg <= 10'h000;
            cntReg <= 12'h000;
            pulseReg <= 4'h0;
            rdataReg <= 8'h00;
            arrReg <= '0;
        end else if (ce) begin
            stateReg <= stateNext;
            doneReg <= doneNext;
            rdcolReg <= rdcolNext;
            accReg <= accNext;
            fpvReg <= fpvNext;
            mgsReg <= mgsNext;
            suspReg <= suspNext;
            pausedReg <= pausedNext;
            passReg <= passNext;
            protReg <= protNext;
            slotReg <= slotNext;
            idxReg <= idxNext;
            cntReg <= cntNext;
            pulseReg <= pulseNext;
            rdataReg <= rdataNext;
            arrReg <= arrNext;
        end
    end
endmodule // fcs_sequencer

// >>> tb/fcs_seq_props.sv
`timescale 1ns/1ps
module fcs_seq_props import fcs_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    // Array and system side
    input wire fcs_arr_s arrReq,
    input wire logic cpuFlashRead,
    input wire logic busy
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Reset value ends in 2'b11 so the first byte of any program command must be aligned
    logic [23:0] lastProgReg;
    logic [23:0] lastProgNext;
    always_comb begin
        lastProgNext = arrReq.prog ? arrReq.addr : lastProgReg;
    end
    always_ff @(posedge sys_clk) begin
        lastProgReg <= rst ? 24'h000003 : lastProgNext;
    end
    sequence s_collide;
        cpuFlashRead && busy;
    endsequence
    sequence s_stat_rd;
        regRd && regAddr == 8'h00;
    endsequence
    a_launch_cause: assert property ($rose(busy) |-> $past(regWr && regAddr == 8'h00 && regWdata[7]))
        else $error("busy rose without launch write");
    a_array_busy: assert property ((arrReq.read || arrReq.prog || arrReq.erase) |-> busy)
        else $error("array access while idle");
    a_prog_readback: assert property (arrReq.prog |-> ##[1:400] arrReq.read)
        else $error("programmed byte not read back");
    a_prog_start: assert property (arrReq.prog && lastProgReg[1:0] == 2'b11 |-> arrReq.addr[1:0] == 2'b00)
        else $error("first programmed byte not aligned");
    a_prog_step: assert property (arrReq.prog && lastProgReg[1:0] != 2'b11 |-> arrReq.addr == lastProgReg + 24'h000001)
        else $error("programmed byte address out of order");
    a_erase_gap: assert property (arrReq.erase |=> (!arrReq.erase)[*8])
        else $error("erase pulses too close");
    a_stat_done: assert property (s_stat_rd |=> regRdata[7] == !$past(busy))
        else $error("complete bit disagrees with busy");
    a_collide_flag: assert property (s_collide ##1 s_stat_rd |=> regRdata[6])
        else $error("collision flag not set");
    a_margin_code: assert property (arrReq.read && arrReq.marginLvl != 2'b00 |-> arrReq.marginLvl != 2'b11)
        else $error("bad margin level");
endmodule // fcs_seq_props

bind fcs_sequencer fcs_seq_props u_props (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .arrReq(arrReq), .cpuFlashRead(cpuFlashRead), .busy(busy));

// >>> tb/tb.sv
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module tb import fcs_pkg::*; ;
    localparam logic [7:0] AST = `FCS_OFF_STAT;
    localparam logic [7:0] ACN = `FCS_OFF_CNFG;
    localparam logic [7:0] APR = `FCS_OFF_PROT;
    localparam logic [7:0] AS0 = `FCS_OFF_SLOT0;
    localparam logic [7:0] OK = 8'h01 << `FCS_ST_DONE;
    localparam logic [7:0] ACC = OK | (8'h01 << `FCS_ST_ACC);
    localparam logic [7:0] FPV = OK | (8'h01 << `FCS_ST_FPV);
    localparam logic [7:0] MGS = OK | (8'h01 << `FCS_ST_MGS);
    localparam logic [7:0] COL = 8'h01 << `FCS_ST_RDCOL;
    localparam logic [7:0] SUSP = 8'h01 << `FCS_CN_SUSP;
    localparam logic [47:0] ERRS [0:11] = '{
        {`FCS_CMD_RDRES, 24'h000100, 8'h00, ACC}, {`FCS_CMD_RDRES, 24'h000008, 8'h01, ACC},
        {`FCS_CMD_RDRES, 24'h000000, 8'h02, ACC}, {`FCS_CMD_RDRES, 24'h000011, 8'h00, ACC},
        {8'h77, 24'h000000, 8'h00, ACC}, {`FCS_CMD_PROG, 24'h000102, 8'h00, ACC},
        {`FCS_CMD_PROG, 24'h008000, 8'h00, ACC}, {`FCS_CMD_ERSSEC, 24'h000101, 8'h00, ACC},
        {`FCS_CMD_PCHECK, 24'h000100, 8'h03, ACC}, {`FCS_CMD_PROG, 24'h001000, 8'h00, FPV},
        {`FCS_CMD_ERSSEC, 24'h001000, 8'h00, FPV}, {`FCS_CMD_PROG, 24'h000200, 8'h00, ACC}};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic cpuFlashRead = 1'b0;
    logic cmdUnavail = 1'b0;
    logic infoWrEn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] infoAddr = 8'h00;
    logic [7:0] infoData = 8'h00;
    logic [7:0] arrRdata;
    logic [7:0] stuck = 8'h00;
    logic [7:0] regRdata;
    logic busy;
    fcs_arr_s arrReq;
    logic [7:0] mem [0:32767];
    int error_cnt = 0;
    int n_tests = 0;

    fcs_sequencer u_fcs_sequencer (.sys_clk(sys_clk), .rst(rst), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .arrReq(arrReq), .arrRdata(arrRdata),
        .cpuFlashRead(cpuFlashRead), .cmdUnavail(cmdUnavail), .infoWrEn(infoWrEn), .infoAddr(infoAddr),
        .infoData(infoData), .busy(busy));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        for (int j = 0; j < 32768; j++) mem[j] = `FCS_ERASED;
    end

    // Array stand-in answers while the read strobe stands; the inverse shows otherwise so a late sample fails
    assign arrRdata = arrReq.read ? mem[arrReq.addr[14:0]] : ~mem[arrReq.addr[14:0]];
    always @(posedge sys_clk) begin
        if (arrReq.prog) begin
            mem[arrReq.addr[14:0]] <= mem[arrReq.addr[14:0]] & (arrReq.wdata | stuck);
        end
        if (arrReq.erase) begin
            for (int j = 0; j < 1024; j++) mem[{arrReq.addr[14:10], 10'(j)}] <= 8'hff;
        end
    end

    task automatic finish_test();
        $display("errors %0d comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        cpuFlashRead <= 1'b0;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, exp);
    endtask

    task automatic wait_done(input int lim);
        int n;
        n = 0;
        @(posedge sys_clk);
        #1;
        while (busy !== 1'b0 && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= lim) begin
            error_cnt++;
            $display("mismatch at %0t: busy %h expected %h", $time, busy, 1'b0);
            finish_test();
        end
    endtask

    // Slots 4-7 take d low byte first, slots 8-11 take x low byte first
    task automatic launch(input logic [7:0] c, input logic [23:0] a, input logic [31:0] d, input logic [31:0] x,
        input int lim);
        wr(AS0, c);
        for (int k = 0; k < 3; k++) wr(AS0 + 8'(k + 1), a[23 - 8 * k -: 8]);
        for (int k = 0; k < 4; k++) wr(AS0 + 8'(k + 4), d[8 * k +: 8]);
        for (int k = 0; k < 4; k++) wr(AS0 + 8'(k + 8), x[8 * k +: 8]);
        wr(AST, 8'h80);
        if (lim > 0) wait_done(lim);
    endtask

    initial begin
        int i;
        logic [47:0] e;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rchk(AST, OK);
        rchk(ACN, 8'h00);
        rchk(APR, `FCS_PROT_RST);
        rchk(AS0, 8'h00);
        wr(8'h03, 8'hff);
        rchk(8'h03, 8'h00);
        wr(APR, 8'h02);
        for (i = 0; i < 12; i++) begin
            e = ERRS[i];
            @(posedge sys_clk);
            cmdUnavail <= (i == 11);
            launch(e[47:40], e[39:16], {24'h0, e[15:8]}, {24'h0, e[15:8]}, 2000);
            rchk(AST, e[7:0]);
            wr(AST, 8'h80);
            rchk(AST, e[7:0]);
            wr(AST, 8'h30);
        end
        cmdUnavail <= 1'b0;
        chk(mem[15'h1000], 8'hff);
        wr(APR, 8'h00);
        for (i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            infoWrEn <= 1'b1;
            infoAddr <= 8'h10 + 8'(i);
            infoData <= 8'ha0 + 8'(i);
        end
        @(posedge sys_clk);
        infoWrEn <= 1'b0;
        launch(`FCS_CMD_RDRES, 24'h000010, 32'h0, 32'h0, 1000);
        rchk(AST, OK);
        for (i = 0; i < 4; i++) rchk(AS0 + 8'(4 + i), 8'ha0 + 8'(i));
        launch(`FCS_CMD_RDRES, 24'h000004, 32'h0, 32'h1, 1000);
        rchk(AST, OK);
        launch(`FCS_CMD_PROG, 24'h000100, 32'h12345678, 32'h0, 2000);
        rchk(AST, OK);
        for (i = 0; i < 4; i++) chk(mem[15'h100 + 15'(i)], 8'(32'h12345678 >> (24 - 8 * i)));
        // A stuck bit 0 stays high in each of the four programmed cells
        stuck = 8'h01;
        launch(`FCS_CMD_PROG, 24'h000104, 32'h0, 32'h0, 2000);
        rchk(AST, MGS);
        stuck = 8'h00;
        for (i = 1; i < 3; i++) begin
            launch(`FCS_CMD_PCHECK, 24'h000100, 32'(i), 32'h12345678, 1000);
            rchk(AST, OK);
        end
        launch(`FCS_CMD_PCHECK, 24'h000100, 32'h1, 32'h12345677, 1000);
        rchk(AST, MGS);
        launch(`FCS_CMD_ERSSEC, 24'h000100, 32'h0, 32'h0, 0);
        wr(ACN, SUSP);
        @(posedge sys_clk);
        cpuFlashRead <= 1'b1;
        rchk(AST, COL);
        wait_done(6000);
        rchk(AST, OK | COL);
        wr(AST, COL);
        rchk(ACN, SUSP);
        wr(AS0, `FCS_CMD_PROG);
        wr(APR, 8'hff);
        rchk(AS0, `FCS_CMD_ERSSEC);
        rchk(APR, 8'h00);
        wr(AST, 8'h80);
        repeat (4) @(posedge sys_clk);
        rchk(ACN, 8'h00);
        rchk(AST, 8'h00);
        // Enable low must swallow a suspend request, or the erase would stop at the next pulse end
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(ACN, SUSP);
        ce <= 1'b1;
        rchk(ACN, 8'h00);
        for (i = 0; i < 40000 && arrReq.read !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk(8'(arrReq.read), 8'h01);
        if (arrReq.read !== 1'b1) finish_test();
        wr(ACN, SUSP);
        wait_done(6000);
        rchk(ACN, 8'h00);
        rchk(AST, OK);
        chk(mem[15'h100], 8'hff);
        wr(ACN, SUSP);
        rchk(ACN, 8'h00);
        finish_test();
    end
endmodule // tb
